// [logic/eeprom_slave.sv]
// Two-wire serial memory slave: address match, page buffer, self-timed programming.
`timescale 1ns/10ps
`default_nettype none
module eeprom_slave #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  output logic standby,
  output logic prog_busy,
  output logic cell_we,
  output eeprom_pkg::cell_word_type cell_word
);

  localparam int PAGES = LARGE_VARIANT ? eeprom_pkg::PAGES_LARGE : eeprom_pkg::PAGES_SMALL;
  localparam logic [7:0] ADDR_MASK = LARGE_VARIANT ? 8'hff : eeprom_pkg::SMALL_ADDR_MASK;
  localparam logic [19:0] LAST_COUNT = 20'(WRITE_CYCLES - 1);

  // ---------------- Start and stop detection on data edges ----------------
  logic start_tog_q, start_tog_d, stop_tog_q, stop_tog_d;

  always_comb begin
    start_tog_d = scl ? ~start_tog_q : start_tog_q;
    stop_tog_d = scl ? ~stop_tog_q : stop_tog_q;
  end

  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      start_tog_q <= 1'b0;
    end else begin
      start_tog_q <= start_tog_d;
    end
  end

  always_ff @(posedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      stop_tog_q <= 1'b0;
    end else begin
      stop_tog_q <= stop_tog_d;
    end
  end

  // ---------------- Link domain, clocked by the master's clock ----------------
  eeprom_pkg::link_state_type state_q, state_d;
  logic seen_q, seen_d;
  logic [3:0] cnt_q, cnt_d;
  logic [6:0] shift_q, shift_d;
  logic ack_q, ack_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] page_q [eeprom_pkg::PAGE_BYTES];
  logic [7:0] page_d [eeprom_pkg::PAGE_BYTES];
  logic [7:0] mask_q, mask_d;
  logic pending_q, pending_d;
  logic busy_s1_q, busy_s2_q;
  logic [2:0] strap_s1_q, strap_s2_q;
  logic oe_q, oe_d;
  logic new_start;
  logic [7:0] byte_in;
  logic addr_match;

  always_comb begin
    new_start = start_tog_q != seen_q;
    byte_in = {shift_q, sda_i};
    addr_match = (byte_in[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB] == eeprom_pkg::DEV_TYPE_CODE)
      && (byte_in[eeprom_pkg::STRAP_MSB:eeprom_pkg::STRAP_LSB] == strap_s2_q);
    state_d = state_q;
    seen_d = seen_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ack_d = 1'b0;
    waddr_d = waddr_q;
    page_d = page_q;
    mask_d = mask_q;
    pending_d = pending_q;
    if (new_start) begin
      // First rising edge after a start carries the top address bit
      seen_d = start_tog_q;
      state_d = eeprom_pkg::LINK_DEV;
      shift_d = {6'h00, sda_i};
      cnt_d = 4'h1;
      pending_d = 1'b0;
      mask_d = eeprom_pkg::MASK_RST;
    end else if (cnt_q == eeprom_pkg::ACK_BIT) begin
      cnt_d = eeprom_pkg::CNT_RST;
    end else if (cnt_q != eeprom_pkg::LAST_DATA_BIT) begin
      shift_d = {shift_q[5:0], sda_i};
      cnt_d = cnt_q + 4'h1;
    end else begin
      cnt_d = eeprom_pkg::ACK_BIT;
      if (busy_s2_q) begin
        state_d = eeprom_pkg::LINK_IGNORE;
      end else begin
        unique case (state_q)
          eeprom_pkg::LINK_DEV: begin
            ack_d = addr_match;
            if (addr_match && !byte_in[eeprom_pkg::RW_BIT]) begin
              state_d = eeprom_pkg::LINK_WADDR;
            end else begin
              state_d = eeprom_pkg::LINK_IGNORE;
            end
          end
          eeprom_pkg::LINK_WADDR: begin
            ack_d = 1'b1;
            waddr_d = byte_in & ADDR_MASK;
            state_d = eeprom_pkg::LINK_DATA;
          end
          eeprom_pkg::LINK_DATA: begin
            ack_d = 1'b1;
            page_d[waddr_q[2:0]] = byte_in;
            mask_d[waddr_q[2:0]] = 1'b1;
            waddr_d = {waddr_q[7:3], waddr_q[2:0] + 3'h1};
            pending_d = 1'b1;
          end
          eeprom_pkg::LINK_IDLE, eeprom_pkg::LINK_IGNORE: begin
            ack_d = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= eeprom_pkg::LINK_IDLE;
      seen_q <= 1'b0;
      cnt_q <= eeprom_pkg::CNT_RST;
      shift_q <= 7'h00;
      ack_q <= 1'b0;
      waddr_q <= eeprom_pkg::ADDR_RST;
      mask_q <= eeprom_pkg::MASK_RST;
      pending_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      strap_s1_q <= eeprom_pkg::STRAP_RST;
      strap_s2_q <= eeprom_pkg::STRAP_RST;
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        page_q[i] <= 8'h00;
      end
    end else begin
      state_q <= state_d;
      seen_q <= seen_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ack_q <= ack_d;
      waddr_q <= waddr_d;
      mask_q <= mask_d;
      pending_q <= pending_d;
      busy_s1_q <= prog_busy;
      busy_s2_q <= busy_s1_q;
      strap_s1_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      strap_s2_q <= strap_s1_q;
      page_q <= page_d;
    end
  end

  // Drive low only from the falling edge after bit eight to the one after bit nine
  always_comb begin
    oe_d = (cnt_q == eeprom_pkg::ACK_BIT) && ack_q;
  end

  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign sda_oe = oe_q;
  assign sda_o = 1'b0;

  // ---------------- System domain: programming cycle ----------------
  logic st_s1_q, st_s2_q, st_s3_q, sp_s1_q, sp_s2_q, sp_s3_q;
  logic start_evt, stop_evt, launch;
  logic armed_q, armed_d;
  logic busy_q, busy_d;
  logic standby_q, standby_d;
  logic [19:0] wcnt_q, wcnt_d;
  logic [3:0] idx_q, idx_d;
  logic [4:0] row_q, row_d;
  logic [7:0] snap_q [eeprom_pkg::PAGE_BYTES];
  logic [7:0] snap_d [eeprom_pkg::PAGE_BYTES];
  logic [7:0] smask_q, smask_d;
  logic we_q, we_d;
  eeprom_pkg::cell_word_type cell_q, cell_d;

  always_comb begin
    start_evt = st_s2_q != st_s3_q;
    stop_evt = sp_s2_q != sp_s3_q;
    // Link registers are frozen once the stop is seen here
    launch = stop_evt && armed_q && pending_q && !busy_q;
    armed_d = armed_q;
    busy_d = busy_q;
    standby_d = standby_q;
    wcnt_d = wcnt_q;
    idx_d = idx_q;
    row_d = row_q;
    snap_d = snap_q;
    smask_d = smask_q;
    we_d = 1'b0;
    cell_d = cell_q;
    if (start_evt) begin
      // A start wakes the memory; while programming it is already awake
      armed_d = 1'b1;
      standby_d = 1'b0;
    end
    if (launch) begin
      armed_d = 1'b0;
      busy_d = 1'b1;
      standby_d = 1'b0;
      wcnt_d = 20'h00000;
      idx_d = 4'h0;
      row_d = waddr_q[7:3];
      snap_d = page_q;
      smask_d = mask_q;
    end else if (stop_evt && !busy_q) begin
      standby_d = 1'b1;
      armed_d = 1'b0;
    end else if (busy_q) begin
      if (idx_q < 4'(eeprom_pkg::PAGE_BYTES)) begin
        idx_d = idx_q + 4'h1;
        we_d = smask_q[idx_q[2:0]];
        cell_d = '{addr: {row_q, idx_q[2:0]}, data: snap_q[idx_q[2:0]]};
      end
      if (wcnt_q == LAST_COUNT) begin
        busy_d = 1'b0;
        standby_d = 1'b1;
      end else begin
        wcnt_d = wcnt_q + 20'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_s1_q <= 1'b0;
      st_s2_q <= 1'b0;
      st_s3_q <= 1'b0;
      sp_s1_q <= 1'b0;
      sp_s2_q <= 1'b0;
      sp_s3_q <= 1'b0;
      armed_q <= 1'b0;
      busy_q <= 1'b0;
      standby_q <= 1'b1;
      wcnt_q <= 20'h00000;
      idx_q <= 4'h0;
      row_q <= 5'h00;
      smask_q <= eeprom_pkg::MASK_RST;
      we_q <= 1'b0;
      cell_q <= '0;
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        snap_q[i] <= 8'h00;
      end
    end else begin
      st_s1_q <= start_tog_q;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      sp_s1_q <= stop_tog_q;
      sp_s2_q <= sp_s1_q;
      sp_s3_q <= sp_s2_q;
      armed_q <= armed_d;
      busy_q <= busy_d;
      standby_q <= standby_d;
      wcnt_q <= wcnt_d;
      idx_q <= idx_d;
      row_q <= row_d;
      snap_q <= snap_d;
      smask_q <= smask_d;
      we_q <= we_d;
      cell_q <= cell_d;
    end
  end

  assign prog_busy = busy_q;
  assign standby = standby_q;
  assign cell_we = we_q;
  assign cell_word = cell_q;

  // ---------------- Checks ----------------
  a_ack_drive: assert property (@(posedge scl) disable iff (!rst_n)
    (cnt_q == eeprom_pkg::ACK_BIT && ack_q && !new_start) |-> sda_oe)
    else $error("acknowledge not driven in ninth clock");

  a_release_data: assert property (@(posedge scl) disable iff (!rst_n)
    (cnt_q != eeprom_pkg::ACK_BIT) |-> !sda_oe)
    else $error("data line driven outside acknowledge clock");

  a_release_ninth: assert property (@(posedge scl) disable iff (!rst_n)
    (cnt_q == eeprom_pkg::ACK_BIT) |=> !sda_oe)
    else $error("data line held after ninth clock");

  a_addr_match: assert property (@(posedge scl) disable iff (!rst_n)
    (state_q == eeprom_pkg::LINK_DEV && cnt_q == eeprom_pkg::LAST_DATA_BIT && !new_start && !busy_s2_q)
    |=> ack_q == $past(addr_match))
    else $error("address acknowledge does not follow match");

  a_busy_silent: assert property (@(posedge scl) disable iff (!rst_n)
    (busy_s2_q && cnt_q == eeprom_pkg::LAST_DATA_BIT && !new_start) |=> !ack_q ##1 !sda_oe)
    else $error("response given while programming");

  a_page_wrap: assert property (@(posedge scl) disable iff (!rst_n)
    (state_q == eeprom_pkg::LINK_DATA && cnt_q == eeprom_pkg::LAST_DATA_BIT && !new_start && !busy_s2_q)
    |=> waddr_q[7:3] == $past(waddr_q[7:3]) && waddr_q[2:0] == 3'($past(waddr_q[2:0]) + 3'h1))
    else $error("page address did not step within its row");

  a_launch_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launch |=> prog_busy && !standby)
    else $error("stop after data did not start programming");

  a_busy_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(prog_busy) |-> prog_busy [*8])
    else $error("programming interval ended too early");

  a_commit_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cell_we |-> prog_busy && cell_word.addr[7:3] == row_q && $past(smask_q[idx_q[2:0]]))
    else $error("unbuffered location committed");

  a_standby_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(prog_busy) |-> standby)
    else $error("no standby after programming");

  c_page_write: cover property (@(posedge ref_clk) disable iff (!rst_n) launch && mask_q == 8'hff);
  c_byte_write: cover property (@(posedge ref_clk) disable iff (!rst_n) launch);
  c_addr_nack: cover property (@(posedge scl) disable iff (!rst_n)
    state_q == eeprom_pkg::LINK_DEV && cnt_q == eeprom_pkg::LAST_DATA_BIT && !addr_match);
  c_commit: cover property (@(posedge ref_clk) disable iff (!rst_n) cell_we);

endmodule
`default_nettype wire

// [logic/eeprom_pkg.sv]
// Constants and types of the serial memory two-wire slave write front end.
package eeprom_pkg;

  // Arbitrary device type code, not that of any real part
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int STRAP_MSB = 3;
  localparam int STRAP_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int ADDR_W = 8;
  localparam int PAGE_BYTES = 8;
  localparam int PAGES_SMALL = 16;
  localparam int PAGES_LARGE = 32;
  localparam logic [7:0] SMALL_ADDR_MASK = 8'h7f;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] STRAP_RST = 3'h0;

  // Programming interval
  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_CYCLE_TIME_NS = 1000000;
  localparam int WRITE_CYCLES = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_DEV,
    LINK_WADDR,
    LINK_DATA,
    LINK_IGNORE
  } link_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cell_word_type;

endpackage

// [test/twi_master_model.sv]
// Two-wire bus master model: start, stop, byte send with acknowledge, dummy clocks.
`timescale 1ns/10ps
`default_nettype none
module twi_master_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Clock moves inside frames and in dummy pulses, 64 ns per data bit, 80 ns per dummy pulse
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic pulse();
    #32 scl = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    #32 scl = 1'b1;
    #32 sda_oe = 1'b1;
    #32 scl = 1'b0;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #32 scl = 1'b1;
    #32 sda_oe = 1'b0;
    #64;
  endtask
  // Data changes only while the clock is low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sda_oe = ~b[i];
      #32 scl = 1'b1;
      #32 scl = 1'b0;
    end
  endtask
  task automatic send_byte(input logic [7:0] b, output logic nak, output logic rel);
    logic a1;
    send_bits(b, 8);
    sda_oe = 1'b0;
    #32 scl = 1'b1;
    #2 a1 = sda;
    #28 nak = a1 | sda;
    #2 scl = 1'b0;
    #16 rel = sda;
    #16;
  endtask
  // Clock until the memory lets go of the data line
  task automatic recover(output int n);
    n = 0;
    sda_oe = 1'b0;
    #16;
    while (sda !== 1'b1 && n < 9) begin
      pulse();
      n++;
    end
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench of the serial memory slave write path.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int WR = 200;
  logic ref_clk, rst_n, m_scl, m_oe, dut_sda_o, dut_oe, sda;
  logic standby, prog_busy, cell_we;
  logic [2:0] straps;
  eeprom_pkg::cell_word_type cell_word;
  logic [15:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  assign sda = ~(m_oe | (dut_oe & ~dut_sda_o));
  twi_master_model u_master (.scl(m_scl), .sda_oe(m_oe), .sda(sda));
  eeprom_slave #(.WRITE_CYCLES(WR), .LARGE_VARIANT(1'b1)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl(m_scl), .sda_i(sda), .sda_o(dut_sda_o), .sda_oe(dut_oe),
    .strap_addr_bit0(straps[0]), .strap_addr_bit1(straps[1]), .strap_addr_bit2(straps[2]),
    .standby(standby), .prog_busy(prog_busy), .cell_we(cell_we), .cell_word(cell_word));
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask
  // Committed bytes are compared against the oldest expectation
  always @(posedge ref_clk) begin
    if (cell_we === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra commit", 16'(cell_we), 16'h0000);
      end else begin
        check("cell word", cell_word, exp_q.pop_front());
      end
    end
  end
  task automatic wait_busy(input logic lvl, input int lim);
    int c;
    c = 0;
    while (prog_busy !== lvl && c < lim) begin
      @(posedge ref_clk);
      c++;
    end
    check("busy level", 16'(prog_busy), 16'(lvl));
  endtask
  function automatic logic [7:0] dev(input logic [3:0] code, input logic [2:0] s, input logic rd);
    return {code, s, rd};
  endfunction
  task automatic write_frame(input logic [7:0] da, input logic [7:0] wa, input int n, input logic ok,
                             input logic probe);
    logic a, r;
    logic [7:0] d, msk;
    logic [7:0] dat [8];
    int k;
    realtime t0;
    msk = 8'h00;
    u_master.start();
    u_master.send_byte(da, a, r);
    check("device ack", 16'(a), 16'(!ok));
    if (n > 0) begin
      u_master.send_byte(wa, a, r);
      check("word ack", 16'(a), 16'(!ok));
      for (k = 0; k < n; k++) begin
        d = 8'($urandom);
        u_master.send_byte(d, a, r);
        check("data ack", 16'(a), 16'(!ok));
        dat[3'(wa[2:0] + k)] = d;
        msk[3'(wa[2:0] + k)] = 1'b1;
      end
    end
    check("ack release", 16'(r), 16'h0001);
    u_master.stop();
    if (ok && n > 0 && !da[0]) begin
      for (k = 0; k < 8; k++) begin
        if (msk[k]) exp_q.push_back({wa[7:3], 3'(k), dat[k]});
      end
      wait_busy(1'b1, 20);
      t0 = $realtime;
      check("standby in busy", 16'(standby), 16'h0000);
      if (probe) begin
        u_master.start();
        u_master.send_byte(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b0), a, r);
        check("busy ack", 16'(a), 16'h0001);
        u_master.stop();
        check("standby probe", 16'(standby), 16'h0000);
      end
      wait_busy(1'b0, WR + 20);
      k = int'(($realtime - t0) / 20.0);
      check("busy length", 16'(k >= WR - 2 && k <= WR + 2), 16'h0001);
      check("standby after", 16'(standby), 16'h0001);
      check("all committed", 16'(exp_q.size()), 16'h0000);
    end else begin
      repeat (10) @(posedge ref_clk);
      check("no programming", 16'(prog_busy), 16'h0000);
      check("standby idle", 16'(standby), 16'h0001);
    end
  endtask
  initial begin
    #1000000;
    fail_count++;
    final_report();
  end
  initial begin
    int n;
    logic a, r;
    rst_n = 1'b0;
    void'($urandom(25));
    straps = 3'($urandom);
    repeat (3) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    check("reset standby", 16'(standby), 16'h0001);
    check("reset busy", 16'(prog_busy), 16'h0000);
    repeat (2) @(posedge ref_clk);
    repeat (4) u_master.pulse();
    for (int c = 0; c < 16; c++) begin
      write_frame(dev(4'(c), straps, 1'b0), 8'h40, 1, c == int'(eeprom_pkg::DEV_TYPE_CODE), 1'b0);
    end
    for (int b = 0; b < 3; b++) begin
      write_frame(dev(eeprom_pkg::DEV_TYPE_CODE, straps ^ 3'(1 << b), 1'b0), 8'h40, 1, 1'b0, 1'b0);
    end
    write_frame(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b1), 8'h00, 0, 1'b1, 1'b0);
    write_frame(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b0), 8'h2d, 9, 1'b1, 1'b1);
    write_frame(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b0), 8'h10, 3, 1'b1, 1'b0);
    write_frame(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b0), 8'hff, 1, 1'b1, 1'b0);
    // Broken transfer: master stalls while the memory acknowledges
    u_master.start();
    u_master.send_bits(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b0), 8);
    u_master.recover(n);
    check("recovery clocks", 16'(n >= 1 && n <= 9), 16'h0001);
    check("released line", 16'(sda), 16'h0001);
    u_master.stop();
    write_frame(dev(eeprom_pkg::DEV_TYPE_CODE, straps, 1'b0), 8'h81, 2, 1'b1, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
